// ===== hdl/pwr_pkg.sv
// Shared constants and types of the power-mode and reset controller
package pwr_pkg;

  // System clock rate
  localparam int unsigned CLK_MHZ = 40;

  // Times as printed, in their own units
  localparam int unsigned SYS_RST_NS       = 1000;
  localparam int unsigned CORE_RST_NS      = 500;
  localparam int unsigned FAULT_DELAY_NS   = 10000;
  localparam int unsigned SUPPLY_SETTLE_US = 1000;

  // Least times round up to whole cycles
  localparam int unsigned SYS_RST_CYC     = (SYS_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned CORE_RST_CYC    = (CORE_RST_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned FAULT_DELAY_CYC = (FAULT_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SUPPLY_SETTLE_CYC_DEF = SUPPLY_SETTLE_US * CLK_MHZ;

  // Counter and key widths
  localparam int unsigned CNT_W = 16;
  localparam int unsigned KEY_W = 16;

  // Keyed cancel sequence for a postponed fault action (arbitrary values)
  localparam logic [15:0] FAULT_KEY1 = 16'hA5C3;
  localparam logic [15:0] FAULT_KEY2 = 16'h3C5A;

  // Reset cause field positions and reset value
  localparam int unsigned CAUSE_W     = 7;
  localparam int unsigned CAUSE_HW    = 0;
  localparam int unsigned CAUSE_SW    = 1;
  localparam int unsigned CAUSE_PMU   = 2;
  localparam int unsigned CAUSE_EVT   = 3;
  localparam int unsigned CAUSE_TRIG  = 4;
  localparam int unsigned CAUSE_EMU   = 5;
  localparam int unsigned CAUSE_FAULT = 6;
  localparam logic [6:0]  CAUSE_RST   = 7'h01;

  // Power and reset sequencer states
  typedef enum logic [4:0] {
    ST_RESET   = 5'h01,
    ST_FULL_ON = 5'h02,
    ST_SLEEP   = 5'h04,
    ST_HIB     = 5'h08,
    ST_SUPPLY  = 5'h10
  } power_state_e;

  // Fault guard states
  typedef enum logic [1:0] {
    FG_IDLE = 2'h1,
    FG_WAIT = 2'h2
  } guard_state_e;

endpackage

// ===== hdl/fault_if.sv
// Carrier between the reset sequencer and the fault guard
`timescale 1ns/1ps
interface fault_if;
  logic                         fault_event;
  logic                         delay_en;
  logic                         key_write;
  logic [pwr_pkg::KEY_W-1:0]    key_data;
  logic                         flush;
  logic                         fire;
  logic                         pending;

  modport guard (input fault_event, delay_en, key_write, key_data, flush,
                 output fire, pending);
  modport ctrl  (output fault_event, delay_en, key_write, key_data, flush,
                 input fire, pending);
endinterface

// ===== hdl/fault_guard.sv
// Fault action postponement behind a keyed cancel sequence
`timescale 1ns/1ps
module fault_guard (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst,
  // Fault path
  fault_if.guard    fi
);

  pwr_pkg::guard_state_e         state_q, state_d;
  logic [pwr_pkg::CNT_W-1:0]     cnt_q, cnt_d;
  logic                          stage_q, stage_d;
  logic                          fire_q, fire_d;

  // Next state of the guard
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    stage_d = stage_q;
    fire_d  = 1'b0;
    case (state_q)
      pwr_pkg::FG_IDLE: begin
        if (fi.fault_event) begin
          if (fi.delay_en) begin
            state_d = pwr_pkg::FG_WAIT;
            cnt_d   = pwr_pkg::FAULT_DELAY_CYC[pwr_pkg::CNT_W-1:0];
            stage_d = 1'b0;
          end else begin
            fire_d = 1'b1;
          end
        end
      end
      pwr_pkg::FG_WAIT: begin
        if (fi.key_write) begin
          if (!stage_q && fi.key_data == pwr_pkg::FAULT_KEY1) begin
            stage_d = 1'b1;
          end else if (stage_q && fi.key_data == pwr_pkg::FAULT_KEY2) begin
            state_d = pwr_pkg::FG_IDLE;
          end else begin
            stage_d = 1'b0;
          end
        end
        if (state_d == pwr_pkg::FG_WAIT) begin
          if (cnt_q <= 16'h0001) begin
            fire_d  = 1'b1;
            state_d = pwr_pkg::FG_IDLE;
          end else begin
            cnt_d = cnt_q - 16'h0001;
          end
        end
      end
      default: state_d = pwr_pkg::FG_IDLE;
    endcase
    if (fi.flush) begin
      state_d = pwr_pkg::FG_IDLE;
      fire_d  = 1'b0;
      stage_d = 1'b0;
    end
  end

  // Guard registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= pwr_pkg::FG_IDLE;
      cnt_q   <= '0;
      stage_q <= 1'b0;
      fire_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      stage_q <= stage_d;
      fire_q  <= fire_d;
    end
  end

  assign fi.fire    = fire_q;
  assign fi.pending = (state_q == pwr_pkg::FG_WAIT);

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence key_done_s;
    fi.pending && stage_q && fi.key_write && fi.key_data == pwr_pkg::FAULT_KEY2;
  endsequence

  guard_cancel_a: assert property (key_done_s |=> !fi.pending && !fi.fire)
    else $error("keyed sequence did not cancel the fault action");
  guard_direct_a: assert property (
    !fi.pending && fi.fault_event && !fi.delay_en && !fi.flush |=> fi.fire)
    else $error("undelayed fault did not fire next cycle");
  guard_expire_a: assert property (
    fi.pending && cnt_q == 16'h0001 && !fi.key_write && !fi.flush |=> fi.fire ##1 !fi.fire)
    else $error("postponed fault did not fire once on expiry");

endmodule

// ===== hdl/power_mode_reset_control.sv
// Power-mode sequencer and reset controller of the processor
`timescale 1ns/1ps
// What this block does
// - After power-up enter full-on with PLL running, clocks on and core power on.
// - Deep sleep gates core and synchronous peripheral clocks, PLL off, power kept.
// - Deep sleep blocks asynchronous peripherals from internal and external accesses.
// - Hibernate stops all clocks, PLL off, drops regulator wake so supply goes away.
// - In hibernate all pads go high impedance.
// - Any reset loads defaults into affected units and holds them idle until release.
// - Leaving a system reset brings the core out ready to boot.
// - Hardware reset clears everything, this controller and its history included, except the fault output pin when it comes in hibernate.
// - System reset clears all units but this controller keeps its own state.
// - Core-only reset touches only the core and comes only from software.
// - Hardware reset is seen when the active-low pin is driven low.
// - Software, power-mode unit, event controller, trigger router or emulator start system reset.
// - A fault either resets the whole chip or toggles the fault output pin.
// - Fault action may be postponed and cancelled by a timely keyed software sequence.
// - Regulator wake output is active high, meaning supply wanted.
// - Hardware reset pin in hibernate reasserts regulator wake, then boots.
module power_mode_reset_control #(
  parameter int unsigned SUPPLY_SETTLE_CYC = pwr_pkg::SUPPLY_SETTLE_CYC_DEF
) (
  // Clock and reset
  input  wire logic                        clk_sys,
  input  wire logic                        rst,
  // External reset pin
  input  wire logic                        hw_reset_in_n,
  // System and core reset requests
  input  wire logic                        reset_control_reg_wr,
  input  wire logic                        power_mode_unit_rst_req,
  input  wire logic                        system_event_controller_rst_req,
  input  wire logic                        trigger_router_rst_req,
  input  wire logic                        emulator_rst_req,
  input  wire logic                        sw_core_reset_req,
  // Power mode requests
  input  wire logic                        deep_sleep_req,
  input  wire logic                        hibernate_req,
  input  wire logic                        wake_req,
  // Fault management
  input  wire logic                        fault_event,
  input  wire logic                        fault_action_reset,
  input  wire logic                        fault_delay_en,
  input  wire logic                        fault_key_wr,
  input  wire logic [pwr_pkg::KEY_W-1:0]   fault_key_data,
  output logic                             fault_signal_out,
  output logic                             fault_pending,
  // Regulator, clocks and pads
  output logic                             regulator_wake_out,
  output logic                             pll_enable,
  output logic                             core_clk_en,
  output logic                             periph_clk_en,
  output logic                             async_access_block,
  output logic                             pad_hiz,
  // Resets to the rest of the chip
  output logic                             sys_reset_out,
  output logic                             core_reset_out,
  output logic                             boot_start,
  output logic [pwr_pkg::CAUSE_W-1:0]      reset_cause
);

  pwr_pkg::power_state_e                   state_q, state_d;
  logic [pwr_pkg::CNT_W-1:0]               cnt_q, cnt_d;
  logic [pwr_pkg::CNT_W-1:0]               core_cnt_q, core_cnt_d;
  logic [pwr_pkg::CAUSE_W-1:0]             cause_q, cause_d;
  logic                                    fault_out_q, fault_out_d;
  logic                                    boot_q, boot_d;
  logic [4:0]                              req_vec;
  logic                                    fault_rst;
  logic                                    active;

  fault_if fi ();

  // Fault path into the guard
  assign fi.fault_event = fault_event;
  assign fi.delay_en    = fault_delay_en;
  assign fi.key_write   = fault_key_wr;
  assign fi.key_data    = fault_key_data;
  assign fi.flush       = sys_reset_out;

  fault_guard u_guard (
    .clk_sys (clk_sys),
    .rst     (rst),
    .fi      (fi.guard)
  );

  // Request decoding
  assign req_vec   = {emulator_rst_req, trigger_router_rst_req, system_event_controller_rst_req,
                      power_mode_unit_rst_req, reset_control_reg_wr};
  assign fault_rst = fi.fire && fault_action_reset;
  assign active    = (state_q == pwr_pkg::ST_FULL_ON) || (state_q == pwr_pkg::ST_SLEEP);

  // Next state of the sequencer
  always_comb begin
    state_d     = state_q;
    cnt_d       = cnt_q;
    cause_d     = cause_q;
    fault_out_d = fault_out_q;
    boot_d      = 1'b0;
    core_cnt_d  = (core_cnt_q != '0) ? core_cnt_q - 16'h0001 : '0;
    if (fi.fire && !fault_action_reset) begin
      fault_out_d = ~fault_out_q;
    end
    case (state_q)
      pwr_pkg::ST_RESET: begin
        core_cnt_d = '0;
        if (cnt_q <= 16'h0001) begin
          state_d = pwr_pkg::ST_FULL_ON;
          boot_d  = 1'b1;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      pwr_pkg::ST_FULL_ON: begin
        if (sw_core_reset_req) begin
          core_cnt_d = pwr_pkg::CORE_RST_CYC[pwr_pkg::CNT_W-1:0];
        end
        if (hibernate_req) begin
          state_d = pwr_pkg::ST_HIB;
        end else if (deep_sleep_req) begin
          state_d = pwr_pkg::ST_SLEEP;
        end
      end
      pwr_pkg::ST_SLEEP: begin
        if (wake_req) begin
          state_d = pwr_pkg::ST_FULL_ON;
        end
      end
      pwr_pkg::ST_HIB: begin
        state_d = pwr_pkg::ST_HIB;
      end
      pwr_pkg::ST_SUPPLY: begin
        if (cnt_q <= 16'h0001) begin
          state_d = pwr_pkg::ST_RESET;
          cnt_d   = pwr_pkg::SYS_RST_CYC[pwr_pkg::CNT_W-1:0];
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      default: state_d = pwr_pkg::ST_RESET;
    endcase
    // System reset keeps this controller's cause history
    if (active && ((|req_vec) || fault_rst)) begin
      state_d    = pwr_pkg::ST_RESET;
      cnt_d      = pwr_pkg::SYS_RST_CYC[pwr_pkg::CNT_W-1:0];
      cause_d    = cause_q | {fault_rst, req_vec, 1'b0};
      core_cnt_d = '0;
    end
    // Pin reset wins over everything
    if (!hw_reset_in_n) begin
      if (state_q == pwr_pkg::ST_HIB) begin
        state_d = pwr_pkg::ST_SUPPLY;
        cnt_d   = SUPPLY_SETTLE_CYC[pwr_pkg::CNT_W-1:0];
        cause_d = pwr_pkg::CAUSE_RST;
      end else if (state_q != pwr_pkg::ST_SUPPLY) begin
        state_d     = pwr_pkg::ST_RESET;
        cnt_d       = pwr_pkg::SYS_RST_CYC[pwr_pkg::CNT_W-1:0];
        cause_d     = pwr_pkg::CAUSE_RST;
        fault_out_d = 1'b0;
        core_cnt_d  = '0;
      end
    end
  end

  // Sequencer registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q     <= pwr_pkg::ST_RESET;
      cnt_q       <= pwr_pkg::SYS_RST_CYC[pwr_pkg::CNT_W-1:0];
      core_cnt_q  <= '0;
      cause_q     <= pwr_pkg::CAUSE_RST;
      fault_out_q <= 1'b0;
      boot_q      <= 1'b0;
    end else begin
      state_q     <= state_d;
      cnt_q       <= cnt_d;
      core_cnt_q  <= core_cnt_d;
      cause_q     <= cause_d;
      fault_out_q <= fault_out_d;
      boot_q      <= boot_d;
    end
  end

  // Mode decode to clocks, supply and pads
  assign regulator_wake_out = (state_q != pwr_pkg::ST_HIB);
  assign pll_enable         = (state_q == pwr_pkg::ST_FULL_ON) ||
                              (state_q == pwr_pkg::ST_RESET);
  assign core_clk_en        = pll_enable;
  assign periph_clk_en      = pll_enable;
  assign async_access_block = (state_q == pwr_pkg::ST_SLEEP);
  assign pad_hiz            = (state_q == pwr_pkg::ST_HIB);
  assign sys_reset_out      = (state_q == pwr_pkg::ST_RESET) || (state_q == pwr_pkg::ST_HIB) ||
                              (state_q == pwr_pkg::ST_SUPPLY);
  assign core_reset_out     = sys_reset_out || (core_cnt_q != '0);
  assign boot_start         = boot_q;
  assign reset_cause        = cause_q;
  assign fault_signal_out   = fault_out_q;
  assign fault_pending      = fi.pending;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence pin_low_awake_s;
    !hw_reset_in_n && state_q != pwr_pkg::ST_HIB && state_q != pwr_pkg::ST_SUPPLY;
  endsequence

  full_on_outs_a: assert property (state_q == pwr_pkg::ST_FULL_ON |->
    pll_enable && core_clk_en && periph_clk_en && regulator_wake_out && !sys_reset_out)
    else $error("full-on outputs wrong");
  sleep_gate_a: assert property (state_q == pwr_pkg::ST_SLEEP |->
    !pll_enable && !core_clk_en && !periph_clk_en && regulator_wake_out)
    else $error("deep sleep gating wrong");
  sleep_block_a: assert property ($rose(state_q == pwr_pkg::ST_SLEEP) |->
    async_access_block && !pad_hiz)
    else $error("deep sleep did not block async accesses");
  hib_supply_a: assert property (state_q == pwr_pkg::ST_FULL_ON && hibernate_req &&
    hw_reset_in_n && req_vec == 5'h00 && !fault_rst |=> !regulator_wake_out && !pll_enable)
    else $error("hibernate entry did not drop supply and clocks");
  hib_pads_a: assert property (state_q == pwr_pkg::ST_HIB |-> pad_hiz && sys_reset_out)
    else $error("pads not three-stated in hibernate");
  hw_reset_a: assert property (pin_low_awake_s |=>
    sys_reset_out && core_reset_out && reset_cause == pwr_pkg::CAUSE_RST && !fault_signal_out)
    else $error("pin reset did not clear controller");
  sys_retain_a: assert property (active && hw_reset_in_n && reset_control_reg_wr |=>
    sys_reset_out && reset_cause[pwr_pkg::CAUSE_SW] && reset_cause[0] == $past(reset_cause[0]))
    else $error("system reset lost controller history");
  boot_release_a: assert property ($fell(sys_reset_out) |-> boot_start && !core_reset_out)
    else $error("reset release without boot start");
  core_only_a: assert property (state_q == pwr_pkg::ST_FULL_ON && sw_core_reset_req &&
    hw_reset_in_n && !hibernate_req && !deep_sleep_req && req_vec == 5'h00 && !fault_rst
    |=> core_reset_out && !sys_reset_out)
    else $error("core-only reset wrong");
  hib_wake_a: assert property (state_q == pwr_pkg::ST_HIB && !hw_reset_in_n |=>
    regulator_wake_out && core_reset_out && state_q == pwr_pkg::ST_SUPPLY)
    else $error("pin in hibernate did not wake regulator");
  fault_toggle_a: assert property (fi.fire && !fault_action_reset && hw_reset_in_n |=>
    fault_signal_out != $past(fault_signal_out))
    else $error("fault pin did not toggle");

endmodule

// ===== tb/regulator_model.sv
// Behavioural model of the core regulator and the off-chip fault watcher
`timescale 1ns/1ps
module regulator_model #(
  parameter int unsigned SETTLE_CYC = 20
) (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // From the controller
  input  wire logic       regulator_wake_out,
  input  wire logic       fault_signal_out,
  // Observations
  output logic            supply_good,
  output logic [7:0]      toggle_count
);
  int unsigned settle_q;
  logic        fault_last_q;

  // Supply drops at once without wake, settles after a delay with wake high
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      settle_q     <= 0;
      supply_good  <= 1'b1;
      fault_last_q <= 1'b0;
      toggle_count <= 8'h00;
    end else begin
      if (regulator_wake_out !== 1'b1) begin
        settle_q    <= 0;
        supply_good <= 1'b0;
      end else if (settle_q < SETTLE_CYC) begin
        settle_q <= settle_q + 1;
      end else begin
        supply_good <= 1'b1;
      end
      fault_last_q <= fault_signal_out;
      if (fault_signal_out !== fault_last_q) begin
        toggle_count <= toggle_count + 8'h01;
      end
    end
  end
endmodule

// ===== tb/tb.sv
// Self-checking testbench of the power-mode and reset controller
`timescale 1ns/1ps
module tb;
  localparam int unsigned SETTLE = 20;
  logic        clk_sys, rst, hw_reset_in_n, sw_core_reset_req;
  logic [4:0]  req;
  logic        deep_sleep_req, hibernate_req, wake_req;
  logic        fault_event, fault_action_reset, fault_delay_en, fault_key_wr;
  logic [15:0] fault_key_data;
  logic        fault_signal_out, fault_pending, regulator_wake_out, pll_enable;
  logic        core_clk_en, periph_clk_en, async_access_block, pad_hiz;
  logic        sys_reset_out, core_reset_out, boot_start, supply_good;
  logic [6:0]  reset_cause, exp_cause;
  logic [7:0]  toggle_count, tc0;
  logic [6:0]  exp_q[$];
  int          fail_count, n_checks, n, src;
  int          seed = 32'h364D66C5;

  power_mode_reset_control #(.SUPPLY_SETTLE_CYC(SETTLE)) i_power_mode_reset_control (
    .clk_sys(clk_sys), .rst(rst), .hw_reset_in_n(hw_reset_in_n),
    .reset_control_reg_wr(req[0]), .power_mode_unit_rst_req(req[1]),
    .system_event_controller_rst_req(req[2]), .trigger_router_rst_req(req[3]),
    .emulator_rst_req(req[4]), .sw_core_reset_req(sw_core_reset_req),
    .deep_sleep_req(deep_sleep_req), .hibernate_req(hibernate_req), .wake_req(wake_req),
    .fault_event(fault_event), .fault_action_reset(fault_action_reset),
    .fault_delay_en(fault_delay_en), .fault_key_wr(fault_key_wr),
    .fault_key_data(fault_key_data), .fault_signal_out(fault_signal_out),
    .fault_pending(fault_pending), .regulator_wake_out(regulator_wake_out),
    .pll_enable(pll_enable), .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en),
    .async_access_block(async_access_block), .pad_hiz(pad_hiz),
    .sys_reset_out(sys_reset_out), .core_reset_out(core_reset_out),
    .boot_start(boot_start), .reset_cause(reset_cause));

  regulator_model #(.SETTLE_CYC(SETTLE)) i_regulator_model (
    .clk_sys(clk_sys), .rst(rst), .regulator_wake_out(regulator_wake_out),
    .fault_signal_out(fault_signal_out), .supply_good(supply_good),
    .toggle_count(toggle_count));

  // Clock of 25 ns
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  // Count negedges while the chosen reset output stays high
  task automatic count_high(input bit core, output int cnt);
    cnt = 0;
    while (((core ? core_reset_out : sys_reset_out) === 1'b1) && cnt < 2000) begin
      cnt++;
      cyc(1);
    end
  endtask

  task automatic wait_idle();
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      n++;
      cyc(1);
    end
    check("boot seen", 16'h0001, 16'(n < 3000));
    cyc(2);
  endtask

  task automatic modes(input logic [5:0] exp);
    check("mode outputs", 16'(exp), {10'h000, pll_enable, core_clk_en, periph_clk_en,
          async_access_block, pad_hiz, regulator_wake_out});
  endtask

  // Each boot pulse retires the oldest expected cause
  always @(negedge clk_sys) begin
    if (boot_start === 1'b1) begin
      if (exp_q.size() == 0) check("unexpected boot", 16'h0000, 16'h0001);
      else check("reset_cause", 16'(exp_q.pop_front()), 16'(reset_cause));
      check("core out of reset at boot", 16'h0000, 16'(core_reset_out));
      check("supply at boot", 16'h0001, 16'(supply_good));
    end
  end

  initial begin
    #(25ns * 20000);
    fail_count++;
    print_verdict();
  end

  initial begin
    {rst, hw_reset_in_n, req, sw_core_reset_req} = {1'b1, 1'b1, 5'h00, 1'b0};
    {deep_sleep_req, hibernate_req, wake_req, fault_event} = 4'h0;
    {fault_action_reset, fault_delay_en, fault_key_wr, fault_key_data} = 19'h00000;
    exp_cause = 7'h01;
    exp_q.push_back(exp_cause);
    cyc(20);
    rst = 1'b0;
    wait_idle();
    modes(6'h39);
    $display("test power-up done");
    // Every request source, then random picks
    for (int i = 0; i < 8; i++) begin
      src = (i < 5) ? i : $unsigned($random(seed)) % 5;
      exp_cause = exp_cause | 7'(2 << src);
      exp_q.push_back(exp_cause);
      req[src] = 1'b1;
      cyc(1);
      req[src] = 1'b0;
      check("core reset with system reset", 16'h0001, 16'(core_reset_out));
      count_high(1'b0, n);
      check("system reset length", 16'(pwr_pkg::SYS_RST_CYC), 16'(n));
      wait_idle();
    end
    $display("test system reset sources done");
    sw_core_reset_req = 1'b1;
    cyc(1);
    sw_core_reset_req = 1'b0;
    check("system reset in core reset", 16'h0000, 16'(sys_reset_out));
    count_high(1'b1, n);
    check("core reset length", 16'(pwr_pkg::CORE_RST_CYC), 16'(n));
    check("no boot after core reset", 16'h0000, 16'(exp_q.size()));
    $display("test core reset done");
    deep_sleep_req = 1'b1;
    cyc(1);
    deep_sleep_req = 1'b0;
    modes(6'h05);
    cyc(5);
    wake_req = 1'b1;
    cyc(1);
    wake_req = 1'b0;
    modes(6'h39);
    $display("test deep sleep done");
    // Undelayed fault toggles the pin, then resets the chip
    tc0 = toggle_count;
    fault_event = 1'b1;
    cyc(1);
    fault_event = 1'b0;
    cyc(4);
    check("fault toggles", 16'(tc0 + 8'h01), 16'(toggle_count));
    fault_action_reset = 1'b1;
    exp_cause = exp_cause | 7'h40;
    exp_q.push_back(exp_cause);
    fault_event = 1'b1;
    cyc(1);
    fault_event = 1'b0;
    cyc(2);
    check("fault chip reset", 16'h0001, 16'(sys_reset_out));
    wait_idle();
    // Postponed fault cancelled by the key pair, then left to fire after a wrong key
    {fault_action_reset, fault_delay_en} = 2'b01;
    tc0 = toggle_count;
    for (int k = 0; k < 2; k++) begin
      fault_event = 1'b1;
      cyc(1);
      fault_event = 1'b0;
      check("fault pending", 16'h0001, 16'(fault_pending));
      fault_key_wr = 1'b1;
      fault_key_data = (k == 0) ? pwr_pkg::FAULT_KEY1 : 16'($random(seed)) | 16'h0001;
      if (fault_key_data == pwr_pkg::FAULT_KEY2) fault_key_data = 16'h0000;
      cyc(1);
      fault_key_data = (k == 0) ? pwr_pkg::FAULT_KEY2 : 16'h0000;
      cyc(1);
      fault_key_wr = 1'b0;
      n = 2;
      while (toggle_count == tc0 && n < pwr_pkg::FAULT_DELAY_CYC + 20) begin
        n++;
        cyc(1);
      end
      if (k == 0) check("cancelled fault", 16'(tc0), 16'(toggle_count));
      else check("fault delay", 16'h0001, 16'(n >= pwr_pkg::FAULT_DELAY_CYC &&
                 n <= pwr_pkg::FAULT_DELAY_CYC + 4));
      cyc(3);
      check("pending cleared", 16'h0000, 16'(fault_pending));
    end
    check("one late toggle", 16'(tc0 + 8'h01), 16'(toggle_count));
    fault_delay_en = 1'b0;
    $display("test fault management done");
    // Second release of the asynchronous reset in mid-run clears the history
    rst = 1'b1;
    cyc(2);
    check("reset cause in reset", 16'h0001, 16'(reset_cause));
    exp_q.push_back(7'h01);
    rst = 1'b0;
    cyc(2);
    check("held after release", 16'h0003, 16'({sys_reset_out, core_reset_out}));
    check("no early boot", 16'h0000, 16'(boot_start));
    wait_idle();
    // Pin reset in full-on beats a request and clears the fault pin
    tc0 = toggle_count;
    fault_event = 1'b1;
    cyc(1);
    fault_event = 1'b0;
    cyc(4);
    check("fault toggles again", 16'(tc0 + 8'h01), 16'(toggle_count));
    check("fault pin before pin reset", 16'h0001, 16'(fault_signal_out));
    hw_reset_in_n = 1'b0;
    req[0] = 1'b1;
    cyc(1);
    req[0] = 1'b0;
    cyc(2);
    hw_reset_in_n = 1'b1;
    check("system reset on pin", 16'h0001, 16'(sys_reset_out));
    check("fault pin cleared", 16'h0000, 16'(fault_signal_out));
    check("pin beats request", 16'h0001, 16'(reset_cause));
    exp_cause = 7'h01;
    exp_q.push_back(exp_cause);
    wait_idle();
    modes(6'h39);
    $display("test pin and mid-run reset done");
    hibernate_req = 1'b1;
    cyc(1);
    hibernate_req = 1'b0;
    modes(6'h02);
    cyc(5);
    check("supply removed", 16'h0000, 16'(supply_good));
    exp_q.push_back(7'h01);
    hw_reset_in_n = 1'b0;
    cyc(1);
    hw_reset_in_n = 1'b1;
    check("wake after pin", 16'h0001, 16'(regulator_wake_out));
    count_high(1'b1, n);
    check("hold until supply", 16'h0001, 16'(n >= SETTLE + pwr_pkg::SYS_RST_CYC));
    wait_idle();
    modes(6'h39);
    $display("test hibernate wake done");
    print_verdict();
  end
endmodule
